// ===== verilog/pfci_pkg.sv
// Package: pin timing, command codes and status bit positions for the flash host controller
package pfci_pkg;
    // Bus clock period in ns
    localparam int CLK_NS = 4;
    // Pin phase lengths in ns (setup and hold, strobe low, read access)
    localparam int SETUP_NS  = 20;
    localparam int STROBE_NS = 40;
    localparam int ACCESS_NS = 100;
    // Phase lengths in cycles, least times rounded up
    localparam int SETUP_CYC  = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    // Longest program time in us and its cycle count
    localparam int PROG_MAX_US = 30;
    localparam int PROG_CYC    = PROG_MAX_US * 1000 / CLK_NS;
    // Typical erase times in ms and their cycle counts
    localparam int SERASE_MS   = 7;
    localparam int CERASE_MS   = 15;
    localparam int SERASE_CYC  = SERASE_MS * 1000000 / CLK_NS;
    localparam int CERASE_CYC  = CERASE_MS * 1000000 / CLK_NS;
    // Unlock addresses and command codes
    localparam logic [16:0] UNLOCK_A1 = 17'h0_5555;
    localparam logic [16:0] UNLOCK_A2 = 17'h0_2AAA;
    localparam logic [7:0]  CODE_AA   = 8'hAA;
    localparam logic [7:0]  CODE_55   = 8'h55;
    localparam logic [7:0]  CODE_PROG = 8'hA0;
    localparam logic [7:0]  CODE_ERS  = 8'h80;
    localparam logic [7:0]  CODE_SEC  = 8'h30;
    localparam logic [7:0]  CODE_CHIP = 8'h10;
    localparam logic [7:0]  ERASED    = 8'hFF;
    // Status bit positions
    localparam int POLL_BIT = 7;
    localparam int ALT_BIT  = 6;
    // Sector size bit count (4 KByte)
    localparam int SECT_BITS = 12;
    // Number of extra confirming reads
    localparam int RECHECK_N = 2;
    // Host commands
    typedef enum logic [1:0] {
        PFCI_OP_READ   = 2'b00,
        PFCI_OP_PROG   = 2'b01,
        PFCI_OP_SERASE = 2'b10,
        PFCI_OP_CERASE = 2'b11
    } pfci_op_t;
endpackage

// ===== verilog/pfci_bus_cycle.sv
// One asynchronous bus cycle (read or write) on the flash pins
`timescale 1ns/1ps
module pfci_bus_cycle
    import pfci_pkg::*;
#(
    parameter int AW = 17
) (
    // Clock and reset
    input  wire logic          core_clk,
    input  wire logic          srst,
    // Cycle request
    input  wire logic          cyc_go,
    input  wire logic          cyc_wr,
    input  wire logic [AW-1:0] cyc_addr,
    input  wire logic [7:0]    cyc_wdata,
    output logic               cyc_done,
    output logic [7:0]         cyc_rdata,
    // Flash pins
    output logic [AW-1:0]      fl_addr,
    output logic               fl_ce_n,
    output logic               fl_oe_n,
    output logic               fl_we_n,
    output logic [7:0]         fl_dq_o,
    output logic               fl_dq_oe,
    input  wire logic [7:0]    fl_dq_i
);
    typedef enum logic [1:0] {
        PFCI_BC_IDLE  = 2'b00,
        PFCI_BC_SETUP = 2'b01,
        PFCI_BC_STRB  = 2'b10,
        PFCI_BC_HOLD  = 2'b11
    } pfci_bc_t;

    pfci_bc_t        st_q, st_d;
    logic [7:0]      cnt_q, cnt_d;
    logic            wr_q, wr_d;
    logic [AW-1:0]   addr_q, addr_d;
    logic [7:0]      wdat_q, wdat_d, rdat_q, rdat_d;
    logic            ce_q, ce_d, oe_q, oe_d, we_q, we_d, done_q, done_d;

    // Phase sequencing: address before strobe, data held past the rising edge
    always_comb begin
        st_d = st_q; cnt_d = cnt_q; wr_d = wr_q; addr_d = addr_q; wdat_d = wdat_q;
        rdat_d = rdat_q; ce_d = ce_q; oe_d = oe_q; we_d = we_q; done_d = 1'b0;
        case (st_q)
            PFCI_BC_IDLE: begin
                if (cyc_go) begin
                    wr_d = cyc_wr; addr_d = cyc_addr; wdat_d = cyc_wdata;
                    ce_d = 1'b0; cnt_d = 8'(SETUP_CYC); st_d = PFCI_BC_SETUP;
                end
            end
            PFCI_BC_SETUP: begin
                cnt_d = cnt_q - 8'h01;
                if (cnt_q == 8'h01) begin
                    // Chip select is already low, so strobe falls last
                    we_d = ~wr_q;
                    oe_d = wr_q; // Read needs both selects low
                    cnt_d = wr_q ? 8'(STROBE_CYC) : 8'(ACCESS_CYC);
                    st_d = PFCI_BC_STRB;
                end
            end
            PFCI_BC_STRB: begin
                cnt_d = cnt_q - 8'h01;
                if (cnt_q == 8'h01) begin
                    rdat_d = fl_dq_i;
                    we_d = 1'b1; oe_d = 1'b1;
                    cnt_d = 8'(SETUP_CYC); st_d = PFCI_BC_HOLD;
                end
            end
            PFCI_BC_HOLD: begin
                cnt_d = cnt_q - 8'h01;
                if (cnt_q == 8'h01) begin
                    ce_d = 1'b1; done_d = 1'b1; st_d = PFCI_BC_IDLE;
                end
            end
            default: st_d = PFCI_BC_IDLE;
        endcase
    end

    // Registers
    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_q <= PFCI_BC_IDLE; cnt_q <= 8'h00; wr_q <= 1'b0; addr_q <= '0;
            wdat_q <= 8'h00; rdat_q <= 8'h00; ce_q <= 1'b1; oe_q <= 1'b1;
            we_q <= 1'b1; done_q <= 1'b0;
        end else begin
            st_q <= st_d; cnt_q <= cnt_d; wr_q <= wr_d; addr_q <= addr_d;
            wdat_q <= wdat_d; rdat_q <= rdat_d; ce_q <= ce_d; oe_q <= oe_d;
            we_q <= we_d; done_q <= done_d;
        end
    end

    assign fl_addr   = addr_q;
    assign fl_ce_n   = ce_q;
    assign fl_oe_n   = oe_q;
    assign fl_we_n   = we_q;
    assign fl_dq_o   = wdat_q;
    // Host drives data only while the device output gate is off
    assign fl_dq_oe  = wr_q && (st_q != PFCI_BC_IDLE) && oe_q;
    assign cyc_done  = done_q;
    assign cyc_rdata = rdat_q;

    weonly_ce_a: assert property (@(posedge core_clk) disable iff (srst)
        !(fl_we_n == 1'b0 && fl_oe_n == 1'b0)) else $error("strobe and gate low together");
    rd_sel_a: assert property (@(posedge core_clk) disable iff (srst)
        !fl_oe_n |-> !fl_ce_n && !fl_dq_oe) else $error("gate low without select");
endmodule

// ===== verilog/pfci_host.sv
// Host controller: unlock sequences, program, erase and status polling for a parallel flash
// Function
// - Write cycles drop write strobe while chip select is held low.
// - Reads hold chip select and output gate low together.
// - Program: three unlock cycles, then address and data cycle.
// - Sector erase: six cycles, last carries 30H and sector address.
// - Chip erase: six cycles, last writes 10H to 5555H.
// - On inconsistent status, read twice more; done only if both valid.
`timescale 1ns/1ps
module pfci_host
    import pfci_pkg::*;
#(
    parameter int AW          = 17,
    parameter int PROG_TO     = PROG_CYC,
    parameter int SERASE_TO   = 4 * SERASE_CYC,
    parameter int CERASE_TO   = 4 * CERASE_CYC
) (
    // Clock and reset
    input  wire logic          core_clk,
    input  wire logic          srst,
    // User request
    input  wire logic          req_valid,
    output logic               req_ready,
    input  wire pfci_op_t      req_op,
    input  wire logic [AW-1:0] req_addr,
    input  wire logic [7:0]    req_wdata,
    // User answer
    output logic               rsp_valid,
    output logic [7:0]         rsp_rdata,
    output logic               rsp_timeout,
    // Flash pins
    output logic [AW-1:0]      fl_addr,
    output logic               fl_ce_n,
    output logic               fl_oe_n,
    output logic               fl_we_n,
    output logic [7:0]         fl_dq_o,
    output logic               fl_dq_oe,
    input  wire logic [7:0]    fl_dq_i
);
    typedef enum logic [2:0] {
        PFCI_IDLE  = 3'b000,
        PFCI_CMD   = 3'b001,
        PFCI_RD    = 3'b010,
        PFCI_POLL  = 3'b011,
        PFCI_CHECK = 3'b100,
        PFCI_RESP  = 3'b101
    } pfci_st_t;

    pfci_st_t      st_q, st_d;
    pfci_op_t      op_q, op_d;
    logic [AW-1:0] addr_q, addr_d;
    logic [7:0]    wdat_q, wdat_d, rdat_q, rdat_d, prev_q, prev_d;
    logic [2:0]    step_q, step_d;
    logic [1:0]    chk_q, chk_d;
    logic          have_q, have_d, to_q, to_d, vld_q, vld_d, busy;
    logic [31:0]   tmr_q, tmr_d;
    logic          cyc_go, cyc_wr, cyc_done;
    logic [AW-1:0] cyc_addr;
    logic [7:0]    cyc_wdata, cyc_rdata;
    logic [7:0]    fin_val;

    // Value that the polled location must show once the write has finished
    function automatic logic [7:0] final_val(input pfci_op_t op, input logic [7:0] wd);
        final_val = (op == PFCI_OP_PROG) ? wd : ERASED;
    endfunction

    // Settled value of the polled byte, held in a net so single bits can be picked
    assign fin_val = final_val(op_q, wdat_q);

    // Number of write cycles in a command sequence
    function automatic logic [2:0] seq_len(input pfci_op_t op);
        seq_len = (op == PFCI_OP_PROG) ? 3'd4 : 3'd6;
    endfunction

    // Address and data of each sequence step
    always_comb begin
        cyc_addr  = UNLOCK_A1;
        cyc_wdata = CODE_AA;
        case (step_q)
            3'd0, 3'd3: begin cyc_addr = UNLOCK_A1; cyc_wdata = CODE_AA; end
            3'd1, 3'd4: begin cyc_addr = UNLOCK_A2; cyc_wdata = CODE_55; end
            3'd2: begin
                cyc_addr  = UNLOCK_A1;
                cyc_wdata = (op_q == PFCI_OP_PROG) ? CODE_PROG : CODE_ERS;
            end
            default: begin
                cyc_addr = UNLOCK_A1;
                cyc_wdata = CODE_CHIP;
                if (op_q == PFCI_OP_SERASE) begin
                    // Low bits cleared: any address inside the sector will do
                    cyc_addr  = {addr_q[AW-1:SECT_BITS], {SECT_BITS{1'b0}}};
                    cyc_wdata = CODE_SEC;
                end
                if (op_q == PFCI_OP_PROG) begin
                    cyc_addr = addr_q; cyc_wdata = wdat_q;
                end
            end
        endcase
        if (st_q != PFCI_CMD) begin
            cyc_addr = addr_q;
            cyc_wdata = 8'h00;
        end
    end

    assign busy   = (st_q == PFCI_CMD) || (st_q == PFCI_RD) || (st_q == PFCI_POLL) ||
                    (st_q == PFCI_CHECK);
    assign cyc_wr = (st_q == PFCI_CMD);

    // Sequencer; steps 3 and 4 are skipped for program so step 5 is its data cycle
    always_comb begin
        st_d = st_q; op_d = op_q; addr_d = addr_q; wdat_d = wdat_q; rdat_d = rdat_q;
        prev_d = prev_q; step_d = step_q; chk_d = chk_q; have_d = have_q; to_d = to_q;
        vld_d = 1'b0; tmr_d = tmr_q; cyc_go = 1'b0;
        if (busy && st_q != PFCI_CMD && st_q != PFCI_RD && tmr_q != 32'h0000_0000) begin
            tmr_d = tmr_q - 32'h0000_0001;
        end
        case (st_q)
            PFCI_IDLE: begin
                if (req_valid) begin
                    op_d = req_op; addr_d = req_addr; wdat_d = req_wdata;
                    step_d = 3'd0; have_d = 1'b0; to_d = 1'b0; chk_d = 2'd0;
                    st_d = (req_op == PFCI_OP_READ) ? PFCI_RD : PFCI_CMD;
                end
            end
            PFCI_RD: begin
                cyc_go = 1'b1;
                if (cyc_done) begin
                    cyc_go = 1'b0; rdat_d = cyc_rdata; st_d = PFCI_RESP;
                end
            end
            PFCI_CMD: begin
                cyc_go = 1'b1;
                if (cyc_done) begin
                    cyc_go = 1'b0;
                    if ((op_q == PFCI_OP_PROG && step_q == 3'd5) || step_q == 3'd5) begin
                        // Operation launched by this last rising strobe
                        st_d = PFCI_POLL;
                        tmr_d = (op_q == PFCI_OP_PROG)   ? 32'(PROG_TO) :
                                (op_q == PFCI_OP_SERASE) ? 32'(SERASE_TO) : 32'(CERASE_TO);
                    end else begin
                        step_d = (op_q == PFCI_OP_PROG && step_q == 3'd2) ? 3'd5 : step_q + 3'd1;
                    end
                end
            end
            PFCI_POLL, PFCI_CHECK: begin
                // Only status reads are issued until completion
                cyc_go = 1'b1;
                if (cyc_done) begin
                    cyc_go = 1'b0; prev_d = cyc_rdata; have_d = 1'b1; rdat_d = cyc_rdata;
                    if (st_q == PFCI_POLL) begin
                        // Bit 6 holds and bit 7 equals that bit of the final value: done if the whole byte matches, else recheck
                        if (have_q && (cyc_rdata[ALT_BIT] == prev_q[ALT_BIT]) &&
                            (cyc_rdata[POLL_BIT] == fin_val[POLL_BIT])) begin
                            if (cyc_rdata == fin_val) begin
                                st_d = PFCI_RESP;
                            end else begin
                                st_d = PFCI_CHECK; chk_d = 2'd0;
                            end
                        end
                    end else begin
                        if (cyc_rdata != fin_val) begin
                            st_d = PFCI_POLL; // Rejection stands
                        end else if (chk_q == 2'(RECHECK_N - 1)) begin
                            st_d = PFCI_RESP;
                        end else begin
                            chk_d = chk_q + 2'd1;
                        end
                    end
                    if (st_d != PFCI_RESP && tmr_q == 32'h0000_0000) begin
                        to_d = 1'b1; st_d = PFCI_RESP;
                    end
                end
            end
            PFCI_RESP: begin
                vld_d = 1'b1; st_d = PFCI_IDLE;
            end
            default: st_d = PFCI_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_q <= PFCI_IDLE; op_q <= PFCI_OP_READ; addr_q <= '0; wdat_q <= 8'h00;
            rdat_q <= 8'h00; prev_q <= 8'h00; step_q <= 3'd0; chk_q <= 2'd0;
            have_q <= 1'b0; to_q <= 1'b0; vld_q <= 1'b0; tmr_q <= 32'h0000_0000;
        end else begin
            st_q <= st_d; op_q <= op_d; addr_q <= addr_d; wdat_q <= wdat_d;
            rdat_q <= rdat_d; prev_q <= prev_d; step_q <= step_d; chk_q <= chk_d;
            have_q <= have_d; to_q <= to_d; vld_q <= vld_d; tmr_q <= tmr_d;
        end
    end

    // Pin driver; chip select returns high between cycles
    pfci_bus_cycle #(.AW(AW)) u_cyc (
        .core_clk  (core_clk),
        .srst      (srst),
        .cyc_go    (cyc_go),
        .cyc_wr    (cyc_wr),
        .cyc_addr  (cyc_addr),
        .cyc_wdata (cyc_wdata),
        .cyc_done  (cyc_done),
        .cyc_rdata (cyc_rdata),
        .fl_addr   (fl_addr),
        .fl_ce_n   (fl_ce_n),
        .fl_oe_n   (fl_oe_n),
        .fl_we_n   (fl_we_n),
        .fl_dq_o   (fl_dq_o),
        .fl_dq_oe  (fl_dq_oe),
        .fl_dq_i   (fl_dq_i)
    );

    assign req_ready   = (st_q == PFCI_IDLE);
    assign rsp_valid   = vld_q;
    assign rsp_rdata   = rdat_q;
    assign rsp_timeout = to_q;

    // Addresses stay stable while write strobe is low
    addr_stable_a: assert property (@(posedge core_clk) disable iff (srst)
        (!fl_we_n && $past(!fl_we_n)) |-> $stable(fl_addr)) else $error("addr moved");
    data_hold_a: assert property (@(posedge core_clk) disable iff (srst)
        $rose(fl_we_n) |-> fl_dq_oe && $stable(fl_dq_o)) else $error("data dropped");
    no_drive_a: assert property (@(posedge core_clk) disable iff (srst)
        fl_dq_oe |-> fl_oe_n) else $error("bus contention");
    poll_rd_a: assert property (@(posedge core_clk) disable iff (srst)
        (st_q == PFCI_POLL) |-> fl_we_n) else $error("write while busy");
    // Ready already stands in the response cycle, so the next request may land at its end
    resp_once_a: assert property (@(posedge core_clk) disable iff (srst)
        rsp_valid |-> req_ready ##1 !rsp_valid) else $error("response twice");
    step_seq_a: assert property (@(posedge core_clk) disable iff (srst)
        (st_q == PFCI_CMD && step_q == 3'd2 && cyc_done && op_q == PFCI_OP_PROG)
        |=> step_q == 3'd5) else $error("program step skip");
    chip_cmd_a: assert property (@(posedge core_clk) disable iff (srst)
        (st_q == PFCI_CMD && step_q == 3'd5 && op_q == PFCI_OP_CERASE)
        |-> cyc_addr == UNLOCK_A1 && cyc_wdata == CODE_CHIP) else $error("chip cmd");
    sec_cmd_a: assert property (@(posedge core_clk) disable iff (srst)
        (st_q == PFCI_CMD && step_q == 3'd5 && op_q == PFCI_OP_SERASE)
        |-> cyc_wdata == CODE_SEC) else $error("sector cmd");

    prog_c: cover property (@(posedge core_clk) rsp_valid && op_q == PFCI_OP_PROG && !rsp_timeout);
    serase_c: cover property (@(posedge core_clk) rsp_valid && op_q == PFCI_OP_SERASE);
    recheck_c: cover property (@(posedge core_clk) st_q == PFCI_CHECK);
    timeout_c: cover property (@(posedge core_clk) rsp_valid && rsp_timeout);
endmodule

// ===== verification/pfci_flash_model.sv
// Behavioural byte-wide parallel flash: unlock sequences, self-timed program/erase, status bits
`timescale 1ns/1ps
module pfci_flash_model
    import pfci_pkg::*;
#(
    parameter int AW        = 17,
    parameter int PROG_NS   = 1000,
    parameter int SERASE_NS = 1500,
    parameter int CERASE_NS = 2000
) (
    // Flash pins, data as the resolved bus level
    input  wire logic [AW-1:0] fl_addr,
    input  wire logic          fl_ce_n,
    input  wire logic          fl_oe_n,
    input  wire logic          fl_we_n,
    input  wire logic [7:0]    fl_dq,
    output logic [7:0]         dev_dq,
    // Knobs: slow stretches times by three, hang holds busy until released
    input  wire logic          slow,
    input  wire logic          hang
);
    logic [7:0]    mem [int];  // Byte per address, absent means erased
    logic          busy;
    logic          torn;  // Next read races completion and catches a half-settled byte
    logic          erase_op;
    logic          tgl;
    logic [7:0]    tgt;
    logic [7:0]    last_q;
    logic [AW-1:0] lat_a;
    int            step;
    wire           wr_n  = fl_we_n | fl_ce_n;
    wire           rd_on = !fl_ce_n && !fl_oe_n;

    initial begin
        busy = 1'b0;
        step = 0;
        tgl = 1'b0;
        torn = 1'b0;
        last_q = 8'h00;
    end

    // Later falling strobe takes the address
    always @(negedge wr_n) lat_a = fl_addr;
    // First rising strobe takes the data; a low gate inhibits the write
    always @(posedge wr_n) if (fl_oe_n === 1'b1) cmd(lat_a, fl_dq);
    // Value is frozen at read start, so completion mid-read gives stale status
    always @(posedge rd_on) begin
        if (busy) tgl = ~tgl;
        last_q = busy ? {erase_op ? 1'b0 : ~tgt[7], tgl, tgt[5:0]} :
                 (mem.exists(int'(fl_addr)) ? mem[int'(fl_addr)] : ERASED);
        // Status bits already settled, low bits not yet: only rereads expose it
        if (!busy && torn) begin
            last_q = {tgt[7], tgl, ~tgt[5:0]};
            torn = 1'b0;
        end
    end
    // Released bus shows the inverse, never a held value
    assign dev_dq = rd_on ? last_q : ~last_q;

    task automatic start(input logic [7:0] d, input logic e, input int t);
        busy = 1'b1;
        erase_op = e;
        tgt = d;
        tgl = 1'b0;
        fork
            begin
                #(slow ? 3 * t : t);
                torn = !hang;
                wait (!hang);
                busy = 1'b0;
            end
        join_none
    endtask

    task automatic cmd(input logic [AW-1:0] a, input logic [7:0] d);
        int ks[$];
        if (busy) return;
        case (step)  // Invalid cycle drops back to read mode
            0, 4: step = (a == UNLOCK_A1 && d == CODE_AA) ? step + 1 : 0;
            1, 5: step = (a == UNLOCK_A2 && d == CODE_55) ? step + 1 : 0;
            2: step = (a != UNLOCK_A1) ? 0 : (d == CODE_PROG) ? 3 : (d == CODE_ERS) ? 4 : 0;
            3: begin
                mem[int'(a)] = d;
                start(d, 1'b0, PROG_NS);
                step = 0;
            end
            default: begin
                if (d == CODE_SEC) begin
                    foreach (mem[k])
                        if ((k >> SECT_BITS) == (int'(a) >> SECT_BITS)) ks.push_back(k);
                    foreach (ks[i]) mem.delete(ks[i]);
                    start(ERASED, 1'b1, SERASE_NS);
                end else if (d == CODE_CHIP && a == UNLOCK_A1) begin
                    mem.delete();
                    start(ERASED, 1'b1, CERASE_NS);
                end
                step = 0;
            end
        endcase
    endtask
endmodule

// ===== verification/testbench.sv
// Testbench: host controller against the flash model, checked by a reference memory
`timescale 1ns/1ps
module testbench;
    import pfci_pkg::*;
    localparam int AW = 17;
    logic          core_clk, srst, req_valid, req_ready, rsp_valid, rsp_timeout, slow, hang;
    pfci_op_t      req_op;
    logic [AW-1:0] req_addr, fl_addr;
    logic [7:0]    req_wdata, rsp_rdata, fl_dq_o, dev_dq, bus;
    logic          fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe;
    logic [AW-1:0] ad [8];
    logic [7:0]    ref_mem [int];
    int            num_errors, tests_run, wr_cnt;

    // Bus level from both drivers
    assign bus = fl_dq_oe ? fl_dq_o : dev_dq;

    pfci_host #(.AW(AW), .PROG_TO(2000), .SERASE_TO(2000), .CERASE_TO(2000)) dut (
        .fl_dq_i(bus), .*);
    pfci_flash_model #(.AW(AW)) u_flash (.fl_dq(bus), .*);

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // Count write pulses that end while selected
    always @(posedge fl_we_n) if (fl_ce_n === 1'b0) wr_cnt++;
    // Host must never drive while the flash output is enabled
    always @(posedge core_clk) begin
        if (fl_dq_oe === 1'b1 && fl_ce_n === 1'b0 && fl_oe_n === 1'b0) begin
            num_errors++;
            $display("[ERR] %0t bus contention", $time);
        end
    end

    task automatic tally_and_finish();
        if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // One request; expectation from the reference memory
    task automatic do_op(input pfci_op_t op, input logic [AW-1:0] a, input logic [7:0] d,
                         input logic to_exp);
        int         n;
        int         ks[$];
        logic [7:0] e;
        logic [7:0] w;
        n = 0;
        while (req_ready !== 1'b1) begin
            if (++n > 100) begin
                num_errors++;
                $display("[ERR] %0t not ready", $time);
                tally_and_finish();
            end
            @(posedge core_clk);
            #1;
        end
        wr_cnt = 0;
        req_valid = 1'b1;
        req_op = op;
        req_addr = a;
        req_wdata = d;
        @(posedge core_clk);
        #1 req_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1) begin
            if (++n > 20000) begin
                num_errors++;
                $display("[ERR] %0t no response", $time);
                tally_and_finish();
            end
            @(posedge core_clk);
            #1;
        end
        case (op)
            PFCI_OP_READ: e = ref_mem.exists(int'(a)) ? ref_mem[int'(a)] : ERASED;
            PFCI_OP_PROG: begin
                ref_mem[int'(a)] = d;
                e = d;
            end
            PFCI_OP_SERASE: begin
                foreach (ref_mem[k])
                    if ((k >> SECT_BITS) == (int'(a) >> SECT_BITS)) ks.push_back(k);
                foreach (ks[i]) ref_mem.delete(ks[i]);
                e = ERASED;
            end
            default: begin
                ref_mem.delete();
                e = ERASED;
            end
        endcase
        if (!to_exp) chk(rsp_rdata, e, "data");
        chk({7'h00, rsp_timeout}, {7'h00, to_exp}, "timeout");
        w = op == PFCI_OP_READ ? 8'h00 : op == PFCI_OP_PROG ? 8'h04 : 8'h06;
        chk(8'(wr_cnt), w, "writes");
        chk({4'h0, fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe}, 8'h0E, "idle");
    endtask

    task automatic read_all();
        for (int i = 0; i < 8; i++) do_op(PFCI_OP_READ, ad[i], 8'h00, 1'b0);
    endtask

    initial begin
        srst = 1'b1;
        req_valid = 1'b0;
        req_op = PFCI_OP_READ;
        req_addr = '0;
        req_wdata = 8'h00;
        slow = 1'b0;
        hang = 1'b0;
        num_errors = 0;
        tests_run = 0;
        wr_cnt = 0;
        void'($urandom(32'hf7fe1f36));
        repeat (4) @(posedge core_clk);
        #1 srst = 1'b0;
        chk({3'h0, req_ready, fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe}, 8'h1E, "reset");
        do_op(PFCI_OP_READ, 17'h1_FFFF, 8'h00, 1'b0);
        // Top and bottom addresses, a neighbour in the top sector, then random
        ad[0] = 17'h1_FFFF;
        ad[1] = 17'h0_0000;
        ad[2] = 17'h1_F000;
        for (int i = 3; i < 8; i++) ad[i] = AW'($urandom);
        for (int i = 0; i < 8; i++) begin
            slow = i[0];
            do_op(PFCI_OP_PROG, ad[i], 8'($urandom), 1'b0);
        end
        read_all();
        do_op(PFCI_OP_SERASE, 17'h1_F123, 8'h00, 1'b0);
        read_all();
        slow = 1'b1;
        do_op(PFCI_OP_CERASE, ad[3], 8'h00, 1'b0);
        read_all();
        // Device held busy: host must give up and report it
        hang = 1'b1;
        do_op(PFCI_OP_PROG, ad[4], 8'h3C, 1'b1);
        hang = 1'b0;
        do_op(PFCI_OP_READ, ad[4], 8'h00, 1'b0);
        tally_and_finish();
    end
endmodule
